/* File: hdl/ocg_cfg.svh */
// Constants for the on-screen display character generation path
`ifndef OCG_CFG_SVH
`define OCG_CFG_SVH
`define OCG_ROM_AW         15
`define OCG_GLYPH_BASE     15'h0000
`define OCG_BANK0_HI_BASE  15'h1000
`define OCG_BANK1_BASE     15'h1000
`define OCG_BANK1_HI_BASE  15'h2000
`define OCG_GLYPH_LIMIT    15'h23FA
`define OCG_LINES_16       5'h10
`define OCG_LINES_18       5'h12
`define OCG_LINES_20       5'h14
`define OCG_FETCH_LAT      2'h1
`endif

/* File: hdl/ocg_char_gen.sv */
// Character generation path: rom mux, glyph addressing, capture, multiplier
//
// Contract
// - Rom address comes from processor bus in program access, else glyph logic at a request; a program address holds until then.
// - Glyph area starts at word zero; program lives above it.
// - Two banks of up to 256 glyphs; one control bit picks the bank.
// - Matrices are 16 wide by 16, 18 or 20 lines.
// - Lines 1 to 16 are sequential words at pointer plus line offset.
// - High resolution: bank zero lines 17 and 18 start at 1000h.
// - Bank one lines 1 to 16 start at word 1000h.
// - High resolution: bank one lines 17 and 18 start at 2000h.
// - Glyph addresses never exceed 9210 words.
// - Addressed rom word is latched into the capture register; a program access in the address state leaves the program word there.
// - Double size repeats each bit twice into high and mid words.
// - Triple size spreads each bit thrice; normal size feeds low only.
// - Character mode: one display ram word gives one glyph and attributes.
// - Caption mode: one display ram word gives two glyphs.
// - Fringing adds a one pixel border beside and below lit pixels.
// - A blanking output switches the external video multiplexor.
`timescale 1ns/1ps
`default_nettype none
`include "ocg_cfg.svh"

module ocg_char_gen
  import ocg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        prog_sel,
  input  wire logic [14:0] cpu_rom_addr,
  input  wire logic [15:0] rom_data,
  input  wire logic        bank_sel,
  input  wire logic        hi_res,
  input  wire logic [1:0]  matrix_fmt,
  input  wire logic [1:0]  size_sel,
  input  wire logic        fringe_en,
  input  wire logic        caption_mode,
  input  wire logic [15:0] display_ram_word,
  input  wire logic        char_half,
  input  wire logic [4:0]  line_num,
  input  wire logic        req_valid,
  output logic             req_ready,
  output logic [14:0]      rom_addr,
  output logic             rom_is_prog,
  output logic [15:0]      capture,
  output logic             line_valid,
  input  wire logic        line_ready,
  output logic [15:0]      mult_high,
  output logic [15:0]      mult_mid,
  output logic [15:0]      mult_low,
  output logic [2:0]       rgb_out,
  output logic             blank_out
);

  ocg_regs_t r_ff;
  ocg_regs_t nxt_r;

  // ==========================================================================
  // Helpers
  // ==========================================================================

  // Glyph word address for a code, bank and line
  function automatic logic [14:0] glyph_addr(input logic [7:0] code,
                                             input logic       bank,
                                             input logic [4:0] line);
    logic [14:0] base;
    logic [14:0] a;
    base = bank ? `OCG_BANK1_BASE : `OCG_GLYPH_BASE;
    if (line < `OCG_LINES_16) begin
      a = base + {3'h0, code, line[3:0]};
    end else begin
      // Up to four extra lines per glyph, in pairs packed in their own area
      a = (bank ? `OCG_BANK1_HI_BASE : `OCG_BANK0_HI_BASE)
          + {5'h00, code, line[0]} + {5'h00, line[4:1] - 4'h8, 5'h00, 1'b0};
    end
    if (a > `OCG_GLYPH_LIMIT) begin
      a = `OCG_GLYPH_LIMIT;
    end
    return a;
  endfunction : glyph_addr

  // Bit replication for enlarged characters
  function automatic ocg_mult_t expand(input logic [15:0] c, input ocg_size_t s);
    ocg_mult_t   m;
    logic [47:0] w3;
    logic [31:0] w2;
    m = '0;
    w2 = '0;
    w3 = '0;
    for (int i = 0; i < 16; i++) begin
      w2[2*i +: 2] = {2{c[i]}};
      w3[3*i +: 3] = {3{c[i]}};
    end
    case (s)
      OCG_SIZE_X2: m = {w2, 16'h0000};
      OCG_SIZE_X3: m = w3;
      default:     m = {32'h0000_0000, c};
    endcase
    return m;
  endfunction : expand

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic [7:0] code;
  logic       push;
  logic       pop;
  logic       full;
  logic       empty;
  logic [4:0] last_line;
  logic [15:0] cap_x;

  always_comb begin
    nxt_r = r_ff;
    // Caption words carry two codes, character words one plus attributes
    code = caption_mode ? (char_half ? display_ram_word[15:8]
                                     : display_ram_word[7:0])
                        : display_ram_word[7:0];
    case (ocg_mtx_t'(matrix_fmt))
      OCG_MTX_18: last_line = `OCG_LINES_18;
      OCG_MTX_20: last_line = `OCG_LINES_20;
      default:    last_line = `OCG_LINES_16;
    endcase
    full  = (r_ff.wr_ptr[0] == r_ff.rd_ptr[0]) && (r_ff.wr_ptr[1] != r_ff.rd_ptr[1]);
    empty = (r_ff.wr_ptr == r_ff.rd_ptr);
    pop   = !empty && line_ready;
    push  = 1'b0;
    // Fringe: widen lit pixels one pixel each side and down from prior line
    cap_x = r_ff.capture;
    if (r_ff.fringe) begin
      cap_x = r_ff.capture | (r_ff.capture << 1) | (r_ff.capture >> 1)
              | r_ff.prev_cap;
    end

    // Rom mux: processor fetch wins whenever selected
    nxt_r.rom_prog = prog_sel;
    if (prog_sel) begin
      nxt_r.rom_addr = cpu_rom_addr;
    end

    case (r_ff.st)
      OCG_ST_IDLE: begin
        nxt_r.req_rdy = 1'b1;
        if (req_valid && r_ff.req_rdy && !prog_sel) begin
          // Lines beyond the matrix read blank glyph word zero
          nxt_r.rom_addr = (line_num < last_line && (hi_res || line_num < `OCG_LINES_16))
                           ? glyph_addr(code, bank_sel, line_num) : `OCG_GLYPH_BASE;
          nxt_r.size   = ocg_size_t'(size_sel);
          nxt_r.fringe = fringe_en;
          nxt_r.fg_rgb = caption_mode ? 3'h7 : display_ram_word[10:8];
          nxt_r.req_rdy = 1'b0;
          nxt_r.st = OCG_ST_ADDR;
        end
      end
      OCG_ST_ADDR: begin
        nxt_r.st = prog_sel ? OCG_ST_ADDR : OCG_ST_CAPT;
      end
      OCG_ST_CAPT: begin
        nxt_r.prev_cap = r_ff.capture;
        nxt_r.capture  = rom_data;
        nxt_r.st = OCG_ST_EXPD;
      end
      OCG_ST_EXPD: begin
        // Stall here while both buffer slots hold words
        if (!full) begin
          push = 1'b1;
          nxt_r.st = OCG_ST_IDLE;
          nxt_r.req_rdy = 1'b1;
        end
      end
      default: nxt_r.st = OCG_ST_IDLE;
    endcase

    if (push) begin
      nxt_r.buf_d[r_ff.wr_ptr[0]] = '{mult: expand(cap_x, r_ff.size),
                                      fg_rgb: r_ff.fg_rgb, fringe: r_ff.fringe};
      nxt_r.wr_ptr = r_ff.wr_ptr + 2'h1;
    end
    if (pop) begin
      nxt_r.rd_ptr = r_ff.rd_ptr + 2'h1;
    end
    // Blank drives the video mux in the cycle after a line is taken (line presented and line_ready)
    nxt_r.blank = !empty && line_ready;
    nxt_r.rgb   = (!empty && line_ready) ? r_ff.buf_d[r_ff.rd_ptr[0]].fg_rgb : 3'h0;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Outputs straight from flops except line_valid, a pointer compare; buffer head is a registered slot
  assign req_ready   = r_ff.req_rdy;
  assign rom_addr    = r_ff.rom_addr;
  assign rom_is_prog = r_ff.rom_prog;
  assign capture     = r_ff.capture;
  assign line_valid  = (r_ff.wr_ptr != r_ff.rd_ptr);
  assign mult_high   = r_ff.buf_d[r_ff.rd_ptr[0]].mult.high;
  assign mult_mid    = r_ff.buf_d[r_ff.rd_ptr[0]].mult.mid;
  assign mult_low    = r_ff.buf_d[r_ff.rd_ptr[0]].mult.low;
  assign rgb_out     = r_ff.rgb;
  assign blank_out   = r_ff.blank;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  prog_mux_a: assert property (prog_sel |=> rom_addr == $past(cpu_rom_addr))
    else $error("program address not routed");
  glyph_limit_a: assert property (!rom_is_prog |-> rom_addr <= `OCG_GLYPH_LIMIT)
    else $error("glyph address past limit");
  capture_load_a: assert property (r_ff.st == OCG_ST_CAPT |=> capture == $past(rom_data))
    else $error("capture missed rom word");
  bank1_base_a: assert property (r_ff.st == OCG_ST_IDLE && req_valid && req_ready
      && !prog_sel && bank_sel && line_num < 5'h10 |=> rom_addr >= 15'h1000)
    else $error("bank one base wrong");
  hires_base_a: assert property (r_ff.st == OCG_ST_IDLE && req_valid && req_ready
      && !prog_sel && !bank_sel && hi_res && line_num == 5'h10
      && matrix_fmt == 2'h1 |=> rom_addr >= 15'h1000)
    else $error("high line area wrong");
  x1_low_a: assert property (r_ff.st == OCG_ST_EXPD && !full && r_ff.size == OCG_SIZE_X1 |=>
      r_ff.buf_d[$past(r_ff.wr_ptr[0])].mult.high == 16'h0000
      && r_ff.buf_d[$past(r_ff.wr_ptr[0])].mult.mid == 16'h0000)
    else $error("normal size used high word");
  fringe_edge_a: assert property (r_ff.st == OCG_ST_EXPD && !full && r_ff.fringe
      && r_ff.size == OCG_SIZE_X1 |=>
      (r_ff.buf_d[$past(r_ff.wr_ptr[0])].mult.low & ($past(r_ff.capture) << 1))
      == ($past(r_ff.capture) << 1))
    else $error("fringe border missing");
  x2_pair_a: assert property (line_valid && mult_low == 16'h0000 && mult_high != 16'h0000
      |-> mult_high[15] == mult_high[14])
    else $error("double size bit not repeated");
  size_hold_a: assert property (r_ff.st != OCG_ST_IDLE |=> $stable(r_ff.size))
    else $error("size changed mid line");
  blank_rgb_a: assert property (!blank_out |-> rgb_out == 3'h0)
    else $error("rgb without blank");
  no_overrun_a: assert property (full |=> !(r_ff.wr_ptr != $past(r_ff.wr_ptr))
      || $past(pop))
    else $error("buffer overrun");

  fetch_c: cover property (r_ff.st == OCG_ST_CAPT ##1 r_ff.st == OCG_ST_EXPD);
  stall_c: cover property (full && !line_ready);
  triple_c: cover property (r_ff.size == OCG_SIZE_X3 && line_valid);
  prog_c: cover property (prog_sel && r_ff.st == OCG_ST_ADDR);

endmodule : ocg_char_gen
`default_nettype wire

/* File: hdl/ocg_pkg.sv */
// Types for the on-screen display character generation path
package ocg_pkg;
  typedef enum logic [1:0] {
    OCG_SIZE_X1 = 2'h0,
    OCG_SIZE_X2 = 2'h1,
    OCG_SIZE_X3 = 2'h2
  } ocg_size_t;

  typedef enum logic [1:0] {
    OCG_MTX_16 = 2'h0,
    OCG_MTX_18 = 2'h1,
    OCG_MTX_20 = 2'h2
  } ocg_mtx_t;

  // Gray along idle -> address -> capture -> expand
  typedef enum logic [1:0] {
    OCG_ST_IDLE = 2'b00,
    OCG_ST_ADDR = 2'b01,
    OCG_ST_CAPT = 2'b11,
    OCG_ST_EXPD = 2'b10
  } ocg_state_t;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] mid;
    logic [15:0] low;
  } ocg_mult_t;

  // One entry of the output buffer
  typedef struct packed {
    ocg_mult_t  mult;
    logic [2:0] fg_rgb;
    logic       fringe;
  } ocg_line_t;

  typedef struct packed {
    ocg_state_t  st;
    logic [14:0] rom_addr;
    logic        rom_prog;
    logic [15:0] capture;
    ocg_size_t   size;
    logic [2:0]  fg_rgb;
    logic        fringe;
    logic        req_rdy;
    ocg_line_t [1:0] buf_d;
    logic [1:0]  wr_ptr;
    logic [1:0]  rd_ptr;
    logic [15:0] prev_cap;
    logic [2:0]  rgb;
    logic        blank;
  } ocg_regs_t;
endpackage : ocg_pkg

/* File: tb/ocg_rom_model.sv */
// Glyph rom model standing behind the character generator
`timescale 1ns/1ps
`default_nettype none

module ocg_rom_model (
  input  wire logic [14:0] rom_addr,
  output logic      [15:0] rom_data
);
  // ======================================
  // Rom array
  // First glyph of each bank kept blank; pattern elsewhere so a wrong word shows
  always_comb begin
    if (rom_addr[14:4] == 11'h000 || rom_addr[14:4] == 11'h100) begin
      rom_data = 16'h0000;
    end else begin
      rom_data = {rom_addr[7:0] ^ 8'h5A, rom_addr[14:7]};
    end
  end
endmodule : ocg_rom_model

`default_nettype wire

/* File: tb/test_ocg_char_gen.sv */
// Self-checking bench for the character generation path
`timescale 1ns/1ps
`default_nettype none

module test_ocg_char_gen;
  import ocg_pkg::*;
  logic        clk, reset, prog_sel, bank_sel, hi_res, fringe_en, caption_mode;
  logic        char_half, req_valid, line_ready, req_ready, rom_is_prog, line_valid, blank_out;
  logic [14:0] cpu_rom_addr, rom_addr;
  logic [15:0] rom_data, display_ram_word, capture, mult_high, mult_mid, mult_low;
  logic [1:0]  matrix_fmt, size_sel;
  logic [4:0]  line_num;
  logic [2:0]  rgb_out;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [50:0] expq[$];

  ocg_char_gen dut (.clk(clk), .reset(reset), .prog_sel(prog_sel), .cpu_rom_addr(cpu_rom_addr),
    .rom_data(rom_data), .bank_sel(bank_sel), .hi_res(hi_res), .matrix_fmt(matrix_fmt),
    .size_sel(size_sel), .fringe_en(fringe_en), .caption_mode(caption_mode),
    .display_ram_word(display_ram_word), .char_half(char_half), .line_num(line_num),
    .req_valid(req_valid), .req_ready(req_ready), .rom_addr(rom_addr),
    .rom_is_prog(rom_is_prog), .capture(capture), .line_valid(line_valid),
    .line_ready(line_ready), .mult_high(mult_high), .mult_mid(mult_mid), .mult_low(mult_low),
    .rgb_out(rgb_out), .blank_out(blank_out));

  ocg_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));

  // ======================================
  // Clock and hang guard
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Whole run needs a few hundred cycles; generous ceiling
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  // ======================================
  // Expectation helpers
  function automatic logic [15:0] romw(input logic [14:0] a);
    return (a[14:4] == 11'h000 || a[14:4] == 11'h100) ? 16'h0000 : {a[7:0] ^ 8'h5A, a[14:7]};
  endfunction : romw

  function automatic logic [14:0] ea(input logic b, h, input logic [1:0] f,
                                     input logic [7:0] c, input logic [4:0] l);
    if (l < 5'h10) return (b ? 15'h1000 : 15'h0000) + {3'h0, c, 4'h0} + {10'h000, l};
    if (h && l < 5'h10 + {2'h0, f, 1'h0})
      return (b ? 15'h2000 : 15'h1000) + {6'h00, c, 1'h0} + {14'h0000, l[0]} + {6'h00, l[3:1], 6'h00};
    return 15'h0000;
  endfunction : ea

  // Bit widening, MSB first
  function automatic logic [47:0] expand(input logic [15:0] c, input logic [1:0] s);
    logic [47:0] r;
    r = 48'h0;
    for (int i = 0; i < 16; i++) begin
      if (s == 2'h1) r[16 + 2 * i +: 2] = {2{c[i]}};
      else if (s == 2'h2) r[3 * i +: 3] = {3{c[i]}};
    end
    if (s == 2'h0) r[15:0] = c;
    return r;
  endfunction : expand

  // Fringe: lit pixels widened sideways and merged with the line above
  function automatic logic [15:0] fr(input logic [15:0] w, p);
    return w | (w << 1) | (w >> 1) | p;
  endfunction : fr

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // ======================================
  // Access tasks
  // One line request; full marks a request that the stalled buffer must hold off
  task automatic req(input logic b, h, input logic [1:0] f, s, input logic [7:0] c,
                     input logic [4:0] l, input logic cap, input logic full);
    logic [14:0] a;
    int          k;
    a = ea(b, h, f, c, l);
    @(negedge clk);
    bank_sel = b;
    hi_res = h;
    matrix_fmt = f;
    size_sel = s;
    line_num = l;
    caption_mode = cap;
    char_half = 1'h1;
    display_ram_word = cap ? {c, ~c} : {5'h00, c[2:0] ^ 3'h5, c};
    req_valid = 1'h1;
    k = 0;
    while (req_ready !== 1'h1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    req_valid = 1'h0;
    expq.push_back({cap ? 3'h7 : c[2:0] ^ 3'h5, expand(romw(a), s)});
    k = 0;
    while (req_ready !== 1'h1 && k < 12) begin
      @(negedge clk);
      k++;
    end
    chk(req_ready, !full, "ready");
    if (!full) begin
      chk(rom_addr, a, "addr");
      chk(rom_is_prog, 1'h0, "glyph sel");
      chk(capture, romw(a), "capture");
    end
  endtask : req

  task automatic pop();
    @(negedge clk);
    chk(line_valid, 1'h1, "valid");
    chk({mult_high, mult_mid, mult_low}, expq[0][47:0], "mult");
    line_ready = 1'h1;
    @(negedge clk);
    line_ready = 1'h0;
    chk(blank_out, 1'h1, "blank");
    chk(rgb_out, expq[0][50:48], "rgb");
    void'(expq.pop_front());
  endtask : pop

  task automatic end_sim();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ======================================
  // Test sequence
  initial begin
    {reset, prog_sel, bank_sel, hi_res, fringe_en, caption_mode} = 6'h20;
    {char_half, req_valid, line_ready, line_num, matrix_fmt, size_sel} = 12'h000;
    cpu_rom_addr = 15'h0000;
    display_ram_word = 16'h0000;
    repeat (5) @(negedge clk);
    reset = 1'h0;
    @(negedge clk);
    // Every size, both banks, first and last regular line
    for (int s = 0; s < 3; s++)
      for (int b = 0; b < 2; b++)
        for (int l = 0; l < 16; l += 15) begin
          req(b[0], 1'h0, 2'h0, s[1:0], 8'h21 + 8'(s * 8'h41), l[4:0], 1'h0, 1'h0);
          pop();
        end
    // Extra lines in each matrix, past the matrix reads the blank word
    for (int f = 0; f < 3; f++)
      for (int l = 16; l < 20; l++) begin
        req(l[0], 1'h1, f[1:0], 2'h2, 8'hB7, l[4:0], 1'h0, 1'h0);
        pop();
      end
    req(1'h0, 1'h0, 2'h1, 2'h1, 8'h6D, 5'h10, 1'h0, 1'h0);
    pop();
    req(1'h1, 1'h0, 2'h0, 2'h0, 8'h47, 5'h03, 1'h1, 1'h0);
    pop();
    // Fringed normal-size line; the line above is the caption glyph word
    fringe_en = 1'h1;
    req(1'h0, 1'h0, 2'h0, 2'h0, 8'h33, 5'h04, 1'h0, 1'h0);
    fringe_en = 1'h0;
    expq[0][47:0] = {32'h0, fr(romw(ea(1'h0, 1'h0, 2'h0, 8'h33, 5'h04)),
                              romw(ea(1'h1, 1'h0, 2'h0, 8'h47, 5'h03)))};
    pop();
    // Stalled consumer: two lines held, third one accepted and fetched but held in expand until a pop
    req(1'h1, 1'h0, 2'h0, 2'h1, 8'h12, 5'h02, 1'h0, 1'h0);
    req(1'h0, 1'h0, 2'h0, 2'h0, 8'h34, 5'h05, 1'h0, 1'h0);
    req(1'h0, 1'h0, 2'h0, 2'h2, 8'h56, 5'h09, 1'h0, 1'h1);
    repeat (3) pop();
    @(negedge clk);
    chk(line_valid, 1'h0, "empty");
    // Program fetch owns the rom address
    prog_sel = 1'h1;
    cpu_rom_addr = 15'h5ABC;
    repeat (3) @(negedge clk);
    chk(rom_addr, 15'h5ABC, "prog addr");
    chk(rom_is_prog, 1'h1, "prog sel");
    prog_sel = 1'h0;
    end_sim();
  end
endmodule : test_ocg_char_gen

`default_nettype wire
